// [hdl/self_test_pkg.sv]
package self_test_pkg;

  // Register offsets on the APB slave; byte addresses of aligned words.
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  // Field positions.
  localparam int CTRL_INIT_BIT = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAIL_BIT = 1;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_W = 2;
  localparam int RESULT_W = 8;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Fault codes, written with the first-numbered bit as the most significant.
  localparam logic [7:0] FAULT_NONE = 8'h00;
  localparam logic [7:0] FAULT_DEV_BASE = 8'h80;
  localparam logic [7:0] FAULT_CHAN_BASE = 8'h90;
  localparam logic [7:0] FAULT_CTRL = 8'hA0;
  localparam logic [7:0] FAULT_BUS = 8'hB0;

  // Test patterns are built by repeating this pair over the data width.
  localparam logic [1:0] PAT_PAIR = 2'h2;

  // Wrap-around settling time on the device drivers and receivers.
  localparam int CLK_PERIOD_NS = 8;
  localparam int WRAP_SETTLE_NS = 40;
  localparam int WRAP_SETTLE_CYC = (WRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam int WRAP_WAIT = WRAP_SETTLE_CYC + SYNC_STAGES + 1;

  // Sequencer states, one-hot.
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_RAM_WR = 12'h002,
    ST_RAM_RD = 12'h004,
    ST_RAM_CMP = 12'h008,
    ST_FLOP_SET = 12'h010,
    ST_FLOP_CHK1 = 12'h020,
    ST_FLOP_CLR = 12'h040,
    ST_FLOP_CHK0 = 12'h080,
    ST_WRAP_DRV = 12'h100,
    ST_WRAP_CHK = 12'h200,
    ST_DEV_CHK = 12'h400,
    ST_DONE = 12'h800
  } state_t;

endpackage : self_test_pkg

// [hdl/sync2.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for levels arriving from outside the clock domain.
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync2

// [hdl/scratch_pad_ram.sv]
`timescale 1ns/1ps
// Scratch-pad memory with one registered read port; read data lags the address by one cycle.
module scratch_pad_ram #(
  parameter int DEPTH = 64,
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  // Contents are not reset; the self test writes every word before reading it.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : scratch_pad_ram

// [hdl/disk_controller_self_test.sv]
`timescale 1ns/1ps
module disk_controller_self_test #(
  parameter int NUM_DEV = 2,
  parameter int DATA_W = 8,
  parameter int RAM_DEPTH = 64,
  parameter int NUM_FLOPS = 16
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [self_test_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic BUSY,
  output logic INDICATOR,
  input wire logic MASTER_CLEAR,
  input wire logic [NUM_DEV-1:0] DEV_FAULT,
  input wire logic [DATA_W-1:0] WRAP_IN,
  output logic [DATA_W-1:0] WRAP_OUT,
  output logic WRAP_OE
);
  import self_test_pkg::*;

  localparam int AW = $clog2(RAM_DEPTH);
  localparam int CW = $clog2(RAM_DEPTH + WRAP_WAIT + 1);
  localparam logic [CW-1:0] RAM_LAST = CW'(RAM_DEPTH - 1);
  localparam logic [CW-1:0] WRAP_LAST = CW'(WRAP_WAIT - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  // Refuse sizes the logic cannot serve.
  generate
    if (NUM_DEV < 1 || NUM_DEV > 3 || DATA_W < 2 || DATA_W % 2 != 0 ||
        DATA_W > 32 || RAM_DEPTH < 2 || NUM_FLOPS < 1) begin : bad_params
      $error("disk_controller_self_test: unsupported parameter values");
    end
  endgenerate

  // Pattern for one scratch-pad address; the address is folded in to catch aliasing.
  function automatic logic [DATA_W-1:0] pattern(input logic [CW-1:0] a);
    pattern = DATA_W'(a) ^ {(DATA_W / 2){PAT_PAIR}};
  endfunction : pattern

  // Register decode, shared by the read mux and the write strobes.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  // Lowest-numbered faulting device.
  function automatic logic [7:0] dev_index(input logic [NUM_DEV-1:0] f);
    dev_index = 8'h00;
    for (int i = NUM_DEV - 1; i >= 0; i--) begin
      if (f[i]) begin
        dev_index = 8'(i);
      end
    end
  endfunction : dev_index

  state_t st_r;
  state_t st_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic wphase_r;
  logic [7:0] code_r;
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_st_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_mask_nxt;
  logic [NUM_FLOPS-1:0] flop_r;
  logic mc_s;
  logic mc_d_r;
  logic [NUM_DEV-1:0] dev_s;
  logic [DATA_W-1:0] wrap_s;
  logic [DATA_W-1:0] ram_q;

  // Every outside level passes two flip-flops before anything looks at it.
  sync2 #(.W(1 + NUM_DEV + DATA_W)) u_sync (
    .clk(CLK),
    .reset(RESET),
    .d({MASTER_CLEAR, DEV_FAULT, WRAP_IN}),
    .q({mc_s, dev_s, wrap_s})
  );

  // APB phases and address decode.
  wire setup = PSEL & ~PENABLE;
  wire acc_done = PSEL & PENABLE & PREADY;
  wire hit_ctrl = reg_hit(PADDR, ADDR_CTRL);
  wire hit_stat = reg_hit(PADDR, ADDR_STATUS);
  wire hit_res = reg_hit(PADDR, ADDR_RESULT);
  wire hit_ist = reg_hit(PADDR, ADDR_IRQ_STATUS);
  wire hit_msk = reg_hit(PADDR, ADDR_IRQ_MASK);
  wire mapped = hit_ctrl | hit_stat | hit_res | hit_ist | hit_msk;
  wire acc_ok = acc_done & ~PSLVERR & ~BUSY;
  wire init_wr = acc_ok & PWRITE & hit_ctrl & PWDATA[CTRL_INIT_BIT];
  wire mask_wr = acc_ok & PWRITE & hit_msk;
  wire ist_rd = acc_ok & ~PWRITE & hit_ist;

  // Read mux; the control word reads as zero since it only issues commands.
  wire [31:0] stat_val = (32'(code_r != FAULT_NONE) << STAT_FAIL_BIT) |
                         (32'(BUSY) << STAT_BUSY_BIT);
  wire [31:0] rd_val = hit_stat ? stat_val :
                       hit_res ? 32'(code_r) :
                       hit_ist ? 32'(irq_st_r) :
                       hit_msk ? 32'(irq_mask_r) : 32'h00000000;

  // An access set up while the controller is busy is refused with an error answer.
  wire err_nxt = setup & (BUSY | ~mapped);
  wire [31:0] prdata_nxt = (setup & ~PWRITE & ~err_nxt) ? rd_val : 32'h00000000;

  // Start on a master clear edge or an initialize word; master clear restarts a running test.
  wire mc_rise = mc_s & ~mc_d_r;
  wire start = mc_rise | init_wr;

  // Test step outcomes.
  wire ram_bad = (st_r == ST_RAM_CMP) && (ram_q != pattern(cnt_r));
  wire flop_bad = ((st_r == ST_FLOP_CHK1) && !(&flop_r)) ||
                  ((st_r == ST_FLOP_CHK0) && (|flop_r));
  wire wrap_bad = (st_r == ST_WRAP_CHK) && (wrap_s != WRAP_OUT);
  wire dev_bad = (st_r == ST_DEV_CHK) && (|dev_s);
  wire fail_ev = ram_bad | flop_bad | wrap_bad | dev_bad;
  wire [7:0] fail_code = dev_bad ? (FAULT_DEV_BASE | dev_index(dev_s)) :
                         wrap_bad ? FAULT_CHAN_BASE : FAULT_CTRL;
  wire test_end = (st_r == ST_DONE);
  wire pass_end = test_end && (code_r == FAULT_NONE);
  wire [DATA_W-1:0] wrap_data = wphase_r ? ~pattern(CW'(0)) : pattern(CW'(0));

  // Scratch-pad under test.
  scratch_pad_ram #(.DEPTH(RAM_DEPTH), .W(DATA_W)) u_ram (
    .clk(CLK),
    .we(st_r == ST_RAM_WR),
    .addr(cnt_r[AW-1:0]),
    .wdata(pattern(cnt_r)),
    .rdata(ram_q)
  );

  // Sequencer; a failing step is recorded and the walk goes on, so nothing ever halts.
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_IDLE: begin
        st_nxt = ST_IDLE;
      end
      ST_RAM_WR: begin
        cnt_nxt = (cnt_r == RAM_LAST) ? '0 : cnt_r + CNT_ONE;
        st_nxt = (cnt_r == RAM_LAST) ? ST_RAM_RD : ST_RAM_WR;
      end
      ST_RAM_RD: begin
        st_nxt = ST_RAM_CMP;
      end
      ST_RAM_CMP: begin
        cnt_nxt = (cnt_r == RAM_LAST) ? '0 : cnt_r + CNT_ONE;
        st_nxt = (cnt_r == RAM_LAST) ? ST_FLOP_SET : ST_RAM_RD;
      end
      ST_FLOP_SET: begin
        st_nxt = ST_FLOP_CHK1;
      end
      ST_FLOP_CHK1: begin
        st_nxt = ST_FLOP_CLR;
      end
      ST_FLOP_CLR: begin
        st_nxt = ST_FLOP_CHK0;
      end
      ST_FLOP_CHK0: begin
        st_nxt = ST_WRAP_DRV;
        cnt_nxt = '0;
      end
      ST_WRAP_DRV: begin
        cnt_nxt = cnt_r + CNT_ONE;
        st_nxt = (cnt_r == WRAP_LAST) ? ST_WRAP_CHK : ST_WRAP_DRV;
      end
      ST_WRAP_CHK: begin
        cnt_nxt = '0;
        st_nxt = wphase_r ? ST_DEV_CHK : ST_WRAP_DRV;
      end
      ST_DEV_CHK: begin
        st_nxt = ST_DONE;
      end
      ST_DONE: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (start) begin
      st_nxt = ST_RAM_WR;
      cnt_nxt = '0;
    end
  end

  // Event flags: a completion in the same cycle as the clearing read wins.
  assign irq_st_nxt = (irq_st_r & ~{IRQ_W{ist_rd}}) |
                      (IRQ_W'(test_end) << IRQ_DONE_BIT) |
                      (IRQ_W'(test_end && code_r != FAULT_NONE) << IRQ_FAIL_BIT);
  assign irq_mask_nxt = mask_wr ? PWDATA[IRQ_W-1:0] : irq_mask_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Control flops under test: driven all set, then all reset.
  generate
    for (genvar i = 0; i < NUM_FLOPS; i++) begin : g_flop
      always_ff @(posedge CLK) begin
        if (RESET || st_r == ST_FLOP_CLR) begin
          flop_r[i] <= 1'b0;
        end else if (st_r == ST_FLOP_SET) begin
          flop_r[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // Wrap-around drive; each phase flips the pattern so stuck lines show in one pass.
  always_ff @(posedge CLK) begin
    if (RESET || start) begin
      wphase_r <= 1'b0;
    end else if (st_r == ST_WRAP_CHK) begin
      wphase_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      WRAP_OUT <= '0;
      WRAP_OE <= 1'b0;
    end else begin
      WRAP_OUT <= wrap_data;
      WRAP_OE <= (st_nxt == ST_WRAP_DRV) || (st_nxt == ST_WRAP_CHK);
    end
  end

  // Only the first deviation is kept, so the byte names the earliest failing area.
  always_ff @(posedge CLK) begin
    if (RESET || start) begin
      code_r <= FAULT_NONE;
    end else if (fail_ev && code_r == FAULT_NONE) begin
      code_r <= fail_code;
    end
  end

  // Busy and indicator follow the test; a failure leaves the indicator lit.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      BUSY <= 1'b0;
      INDICATOR <= 1'b0;
    end else if (start) begin
      BUSY <= 1'b1;
      INDICATOR <= 1'b1;
    end else if (test_end) begin
      BUSY <= 1'b0;
      INDICATOR <= ~pass_end;
    end
  end

  // APB answer registers and master clear edge history.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
      mc_d_r <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= err_nxt;
      PRDATA <= prdata_nxt;
      mc_d_r <= mc_s;
    end
  end

  // Interrupt status, mask and the level output.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      irq_st_r <= '0;
      irq_mask_r <= IRQ_MASK_RESET;
      IRQ <= 1'b0;
    end else begin
      irq_st_r <= irq_st_nxt;
      irq_mask_r <= irq_mask_nxt;
      IRQ <= |(irq_st_nxt & irq_mask_nxt);
    end
  end

  // Checks on the design's own behaviour.
  start_busy_a: assert property (@(posedge CLK) disable iff (RESET)
    start |=> BUSY && st_r == ST_RAM_WR)
    else $error("start did not enter the test busy");

  busy_refuse_a: assert property (@(posedge CLK) disable iff (RESET)
    (acc_done && BUSY && $past(BUSY)) |-> PSLVERR)
    else $error("access during test was not answered busy");

  ind_on_a: assert property (@(posedge CLK) disable iff (RESET)
    start |=> INDICATOR)
    else $error("indicator not lit at test start");

  ind_end_a: assert property (@(posedge CLK) disable iff (RESET)
    (test_end && !start) |=> (INDICATOR == (code_r != FAULT_NONE)))
    else $error("indicator wrong at test end");

  code_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    (!BUSY && !start) |=> $stable(code_r))
    else $error("fault byte changed while idle");

  code_form_a: assert property (@(posedge CLK) disable iff (RESET)
    (code_r != FAULT_NONE) |-> code_r[RESULT_W-1])
    else $error("nonzero fault byte without its top bit");

  ram_fault_a: assert property (@(posedge CLK) disable iff (RESET)
    (ram_bad && code_r == FAULT_NONE && !start) |=> code_r == FAULT_CTRL)
    else $error("scratch-pad mismatch not coded as controller fault");

  flop_fault_a: assert property (@(posedge CLK) disable iff (RESET)
    (st_r == ST_FLOP_SET && !start) |=> &flop_r ##2 !(|flop_r))
    else $error("control flops did not take both states");

  wrap_fault_a: assert property (@(posedge CLK) disable iff (RESET)
    (wrap_bad && code_r == FAULT_NONE && !start) |=> code_r == FAULT_CHAN_BASE)
    else $error("wrap mismatch not coded as channel fault");

  finish_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(BUSY) |-> ##[1:1000] !BUSY)
    else $error("self test did not finish in time");

  release_a: assert property (@(posedge CLK) disable iff (RESET)
    (test_end && !start) |=> !BUSY ##1 (st_r == ST_IDLE || BUSY))
    else $error("busy not released after the test");

endmodule : disk_controller_self_test

// [verif/disk_device_model.sv]
`timescale 1ns/1ps
// Far side of the device interface: loops the data lines back and reports device faults.
module disk_device_model #(
  parameter int DATA_W = 8,
  parameter int NUM_DEV = 3
) (
  input wire logic clk,
  input wire logic [DATA_W-1:0] wrap_out,
  input wire logic wrap_oe,
  input wire logic break_wrap,
  input wire logic [NUM_DEV-1:0] fault_req,
  output logic [DATA_W-1:0] wrap_in,
  output logic [NUM_DEV-1:0] dev_fault
);
  logic [DATA_W-1:0] last_r = '0;

  // Remember what was last driven, so a released line can show something else.
  always_ff @(posedge clk) begin
    if (wrap_oe) begin
      last_r <= wrap_out;
    end
  end

  // A released line floats; its inverse keeps stale data from ever matching.
  assign wrap_in = wrap_oe ? (wrap_out ^ {{(DATA_W-1){1'b0}}, break_wrap}) : ~last_r;
  // Fault levels are held by the bench for the whole run of one test.
  assign dev_fault = fault_req;
endmodule : disk_device_model

// [verif/test_disk_controller_self_test.sv]
`timescale 1ns/1ps
// Self-checking bench: register accesses over APB, test starts by both causes.
module test_disk_controller_self_test;
  import self_test_pkg::*;
  localparam int DEPTH = 8;
  localparam int DUR = 3 * DEPTH + 4 + 2 * (WRAP_WAIT + 1) + 2;
  logic CLK = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mclr = 1'b0;
  logic brk = 1'b0;
  logic [2:0] freq = 3'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, busy, ind, woe;
  logic [2:0] dflt;
  logic [7:0] win, wout;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  disk_controller_self_test #(.NUM_DEV(3), .DATA_W(8), .RAM_DEPTH(DEPTH), .NUM_FLOPS(16)) dut (
    .CLK(CLK), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .BUSY(busy), .INDICATOR(ind), .MASTER_CLEAR(mclr), .DEV_FAULT(dflt),
    .WRAP_IN(win), .WRAP_OUT(wout), .WRAP_OE(woe));

  disk_device_model #(.DATA_W(8), .NUM_DEV(3)) dev (
    .clk(CLK), .wrap_out(wout), .wrap_oe(woe), .break_wrap(brk), .fault_req(freq),
    .wrap_in(win), .dev_fault(dflt));

  // Clock of 8 ns; the cycle counter cuts a hang short.
  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      $display("ERROR timeout expected 0 seen %0d", cyc);
      mismatches++;
      results();
    end
  end

  task automatic results();
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; pready, prdata and pslverr are taken at the rising edge that completes it.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge CLK);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge CLK);
    penable <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1'b1, pready);
  endtask : apb

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] d;
    logic r;
    apb(1'b0, a, 32'h0, d, r);
    chk(nm, e, d);
    chk({nm, " err"}, ee, r);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] x;
    logic r;
    apb(1'b1, a, d, x, r);
    chk("write err", ee, r);
  endtask : wr

  // Start by init word: busy and lamp rise at the edge that completes the write; checked one edge later.
  task automatic init_start();
    wr(ADDR_CTRL, 32'h1, 1'b0);
    @(posedge CLK);
    @(negedge CLK);
    chk("busy", 1'b1, busy);
    chk("indicator", 1'b1, ind);
  endtask : init_start

  task automatic mclr_start();
    int n;
    n = 0;
    @(posedge CLK);
    mclr <= 1'b1;
    do begin
      @(negedge CLK);
      n++;
    end while (busy !== 1'b1 && n < 10);
    chk("busy", 1'b1, busy);
    chk("indicator", 1'b1, ind);
    @(posedge CLK);
    mclr <= 1'b0;
  endtask : mclr_start

  // Waits for the test end; the run must visit every location and never stall.
  task automatic finish_wait();
    int n;
    n = 1;
    do begin
      @(negedge CLK);
      n++;
    end while (busy === 1'b1 && n < 400);
    chk("busy", 1'b0, busy);
    chk("long enough", 1'b1, n >= 3 * DEPTH);
    chk("not too long", 1'b1, n <= DUR + 2);
    repeat (2) @(negedge CLK);
  endtask : finish_wait

  initial begin
    repeat (8) @(posedge CLK);
    reset <= 1'b0;
    @(negedge CLK);
    chk("busy", 1'b0, busy);
    chk("indicator", 1'b0, ind);
    rd("status", ADDR_STATUS, 32'h0, 1'b0);
    rd("result", ADDR_RESULT, FAULT_NONE, 1'b0);
    rd("mask", ADDR_IRQ_MASK, IRQ_MASK_RESET, 1'b0);
    rd("ctrl", ADDR_CTRL, 32'h0, 1'b0);
    rd("unmapped", 8'h14, 32'h0, 1'b1);
    wr(8'h14, 32'hFFFF_FFFF, 1'b1);
    // Passing run with only the fail event unmasked.
    wr(ADDR_IRQ_MASK, 32'h2, 1'b0);
    init_start();
    rd("status busy", ADDR_STATUS, 32'h0, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h3, 1'b1);
    chk("busy", 1'b1, busy);
    finish_wait();
    chk("indicator", 1'b0, ind);
    chk("irq", 1'b0, irq);
    rd("mask", ADDR_IRQ_MASK, 32'h2, 1'b0);
    rd("result", ADDR_RESULT, FAULT_NONE, 1'b0);
    rd("status", ADDR_STATUS, 32'h0, 1'b0);
    rd("irq status", ADDR_IRQ_STATUS, 32'h1, 1'b0);
    rd("irq status", ADDR_IRQ_STATUS, 32'h0, 1'b0);
    // Each device fault code, started by master clear.
    wr(ADDR_IRQ_MASK, 32'h3, 1'b0);
    for (int i = 0; i < 3; i++) begin
      freq <= 3'h1 << i;
      mclr_start();
      finish_wait();
      chk("indicator", 1'b1, ind);
      chk("irq", 1'b1, irq);
      rd("result", ADDR_RESULT, FAULT_DEV_BASE + i, 1'b0);
      rd("status", ADDR_STATUS, 32'h2, 1'b0);
      rd("irq status", ADDR_IRQ_STATUS, 32'h3, 1'b0);
      @(negedge CLK);
      chk("irq", 1'b0, irq);
      rd("result", ADDR_RESULT, FAULT_DEV_BASE + i, 1'b0);
    end
    // Wrap mismatch comes before the device check, so its code is kept.
    brk <= 1'b1;
    init_start();
    finish_wait();
    rd("result", ADDR_RESULT, FAULT_CHAN_BASE, 1'b0);
    chk("indicator", 1'b1, ind);
    // A clean run after a failure clears the byte and the lamp.
    brk <= 1'b0;
    freq <= 3'h0;
    init_start();
    finish_wait();
    rd("result", ADDR_RESULT, FAULT_NONE, 1'b0);
    chk("indicator", 1'b0, ind);
    results();
  end
endmodule : test_disk_controller_self_test
